/* rtl/dac_serial_ctrl.sv */
// Serial register interface and control logic of a 20-bit voltage converter
`timescale 1ns/1ps
module dac_serial_ctrl (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Supply monitor
	input wire logic SUPPLY_OK,
	// Serial link
	input wire logic SCLK,
	input wire logic SYNC_N,
	input wire logic SDI,
	output logic SDO,
	output logic ALARM_N,
	// Converter controls
	output logic [19:0] DAC_CODE,
	output logic OUTPUT_POWER_DOWN,
	output logic DEGLITCH_BYPASS,
	output logic SETTLE_SPEED_SELECT,
	output logic [1:0] DEGLITCH_STEP_MASK,
	output logic [1:0] UPDATE_RATE,
	output logic CAL_BUSY,
	output logic CAL_DONE_FLAG,
	// AXI4-Lite write
	input wire logic [3:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [3:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	typedef struct packed {
		dac_ctrl_pkg::serial_in_t s1;
		dac_ctrl_pkg::serial_in_t s2;
		dac_ctrl_pkg::serial_in_t s3;
		logic sup1;
		logic sup2;
	} sync_t;
	typedef struct packed {
		dac_ctrl_pkg::frame_t fr;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic sdo;
		logic [31:0] rd_word;
		logic rd_pend;
		logic [23:0] code;
		logic [23:0] setup1;
		logic [23:0] clear;
		logic [23:0] setup2;
		logic [19:0] dac_out;
		logic cal_run;
		logic cal_done;
		logic [15:0] cal_cnt;
		logic alarm_n;
	} core_t;
	typedef struct packed {
		sync_t syn;
		core_t c;
	} state_t;
	localparam core_t CORE_RST = '{
		fr: dac_ctrl_pkg::FR_IDLE,
		code: dac_ctrl_pkg::CODE_RST,
		setup1: dac_ctrl_pkg::SETUP1_RST,
		clear: dac_ctrl_pkg::CLEAR_RST,
		setup2: dac_ctrl_pkg::SETUP2_RST,
		alarm_n: 1'b1,
		default: '0
	};
	// Synchroniser resets to the idle pin levels so no false select edge follows reset
	localparam dac_ctrl_pkg::serial_in_t PIN_IDLE = '{sclk: 1'b0, sync_n: 1'b1, sdi: 1'b0};
	localparam state_t ST_RST = '{syn: '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, sup1: 1'b0,
		sup2: 1'b0}, c: CORE_RST};
	state_t st_r;
	state_t n;
	logic sclk_fall;
	logic sclk_rise;
	logic sync_fall;
	logic sync_rise;
	logic chain;
	logic commit;
	logic [31:0] word;
	logic [6:0] addr;
	logic [23:0] pay;
	logic [23:0] rb;
	logic [15:0] cal_cycles;
	////////////////////////////////////////////////////////////////////////
	// Edge detection on the synchronised link pins
	assign sclk_fall = st_r.syn.s3.sclk && !st_r.syn.s2.sclk;
	assign sclk_rise = !st_r.syn.s3.sclk && st_r.syn.s2.sclk;
	assign sync_fall = st_r.syn.s3.sync_n && !st_r.syn.s2.sync_n;
	assign sync_rise = !st_r.syn.s3.sync_n && st_r.syn.s2.sync_n;
	assign chain = !st_r.c.setup1[dac_ctrl_pkg::BIT_CHAIN_DISABLE];
	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		n = st_r;
		commit = 1'b0;
		word = st_r.c.sh;
		rb = 24'h000000;
		n.syn.s1 = '{sclk: SCLK, sync_n: SYNC_N, sdi: SDI};
		n.syn.s2 = st_r.syn.s1;
		n.syn.s3 = st_r.syn.s2;
		n.syn.sup1 = SUPPLY_OK;
		n.syn.sup2 = st_r.syn.sup1;
		// Calibration countdown
		if (st_r.c.cal_run)
		begin
			if (st_r.c.cal_cnt <= 16'h0001)
			begin
				n.c.cal_run = 1'b0;
				n.c.cal_done = 1'b1;
			end
			else
			begin
				n.c.cal_cnt = st_r.c.cal_cnt - 16'h0001;
			end
		end
		// Frame tracking and shifting
		if (sync_fall)
		begin
			n.c.fr = dac_ctrl_pkg::FR_SHIFT;
			n.c.cnt = 6'h00;
			if (st_r.c.rd_pend)
			begin
				n.c.sh = st_r.c.rd_word;
				n.c.rd_pend = 1'b0;
			end
		end
		else if (st_r.c.fr == dac_ctrl_pkg::FR_SHIFT)
		begin
			if (sync_rise)
			begin
				n.c.fr = dac_ctrl_pkg::FR_IDLE;
				commit = chain && (st_r.c.cnt >= dac_ctrl_pkg::FRAME_BITS);
			end
			else
			begin
				if (sclk_fall)
				begin
					n.c.sh = {st_r.c.sh[30:0], st_r.syn.s2.sdi};
					if (st_r.c.cnt != dac_ctrl_pkg::CNT_MAX)
						n.c.cnt = st_r.c.cnt + 6'h01;
					if (!chain && st_r.c.cnt == dac_ctrl_pkg::FRAME_BITS - 6'h01)
					begin
						commit = 1'b1;
						word = n.c.sh;
					end
				end
				if (sclk_rise)
					n.c.sdo = st_r.c.sh[31];
			end
		end
		// Decode of a completed frame
		addr = word[dac_ctrl_pkg::ADDR_HI:dac_ctrl_pkg::ADDR_LO];
		pay = {word[dac_ctrl_pkg::DATA_HI:dac_ctrl_pkg::DATA_LO], 4'h0};
		if (commit && word[dac_ctrl_pkg::RW_BIT])
		begin
			case (addr)
				dac_ctrl_pkg::A_CODE: rb = st_r.c.code;
				dac_ctrl_pkg::A_SETUP1: rb = st_r.c.setup1;
				dac_ctrl_pkg::A_CLEAR: rb = st_r.c.clear;
				dac_ctrl_pkg::A_STATUS: rb[dac_ctrl_pkg::BIT_CAL_DONE_FLAG] = st_r.c.cal_done;
				dac_ctrl_pkg::A_SETUP2: rb = st_r.c.setup2;
				default: rb = 24'h000000;
			endcase
			n.c.rd_word = {word[dac_ctrl_pkg::RW_BIT:dac_ctrl_pkg::ADDR_LO], rb};
			n.c.rd_pend = 1'b1;
		end
		else if (commit)
		begin
			case (addr)
				dac_ctrl_pkg::A_CODE:
				begin
					n.c.code = pay;
					if (!st_r.c.setup1[dac_ctrl_pkg::BIT_LOAD_MODE_SELECT])
						n.c.dac_out = pay[dac_ctrl_pkg::DATA_HI:dac_ctrl_pkg::DATA_LO];
				end
				dac_ctrl_pkg::A_SETUP1:
				begin
					n.c.setup1 = pay;
					if (st_r.c.setup1[dac_ctrl_pkg::BIT_SETTLE_SPEED_SELECT] ||
						st_r.c.setup2[dac_ctrl_pkg::BIT_DEGLITCH_BYPASS])
						n.c.setup1[19:18] = st_r.c.setup1[19:18];
				end
				dac_ctrl_pkg::A_CLEAR: n.c.clear = pay;
				dac_ctrl_pkg::A_TRIGGER:
				begin
					if (pay[dac_ctrl_pkg::BIT_THERMAL_CAL_START] && !st_r.c.cal_run &&
						st_r.c.setup1[dac_ctrl_pkg::BIT_THERMAL_CAL_ENABLE])
					begin
						n.c.cal_run = 1'b1;
						n.c.cal_done = 1'b0;
						n.c.cal_cnt = cal_cycles;
					end
				end
				dac_ctrl_pkg::A_SETUP2: n.c.setup2 = pay;
				default: n.c.rd_pend = st_r.c.rd_pend;
			endcase
		end
		n.c.alarm_n = !(n.c.cal_done && n.c.setup1[dac_ctrl_pkg::BIT_ALARM_PIN_ENABLE]);
		// Supply fault holds every core register at its default; the host-bus cal_cycles keeps its value
		if (!st_r.syn.sup2)
			n.c = CORE_RST;
	end
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			st_r <= ST_RST;
		else
			st_r <= n;
	end
	////////////////////////////////////////////////////////////////////////
	// Host bus
	dac_axi_regs u_axi (
		.clk(CLK),
		.rst(SYS_RST),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.stat_word({29'h00000000, st_r.c.fr == dac_ctrl_pkg::FR_SHIFT, st_r.c.cal_done,
			st_r.c.cal_run}),
		.cal_cycles(cal_cycles)
	);
	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign SDO = st_r.c.sdo;
	assign ALARM_N = st_r.c.alarm_n;
	assign DAC_CODE = st_r.c.dac_out;
	assign OUTPUT_POWER_DOWN = st_r.c.setup1[dac_ctrl_pkg::BIT_OUTPUT_POWER_DOWN];
	assign DEGLITCH_BYPASS = st_r.c.setup2[dac_ctrl_pkg::BIT_DEGLITCH_BYPASS];
	assign SETTLE_SPEED_SELECT = st_r.c.setup1[dac_ctrl_pkg::BIT_SETTLE_SPEED_SELECT];
	assign DEGLITCH_STEP_MASK =
		st_r.c.setup1[dac_ctrl_pkg::DEGLITCH_STEP_MASK_HI:dac_ctrl_pkg::DEGLITCH_STEP_MASK_LO];
	assign UPDATE_RATE =
		st_r.c.setup2[dac_ctrl_pkg::UPDATE_RATE_HI:dac_ctrl_pkg::UPDATE_RATE_LO];
	assign CAL_BUSY = st_r.c.cal_run;
	assign CAL_DONE_FLAG = st_r.c.cal_done;
	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	logic in_frame;
	assign in_frame = st_r.syn.sup2 && st_r.c.fr == dac_ctrl_pkg::FR_SHIFT &&
		!sync_rise && !sync_fall;
	sequence chain_wr_s;
		st_r.syn.sup2 && sync_rise && st_r.c.fr == dac_ctrl_pkg::FR_SHIFT && chain &&
		st_r.c.cnt >= dac_ctrl_pkg::FRAME_BITS && !st_r.c.sh[31] &&
		st_r.c.sh[30:24] == dac_ctrl_pkg::A_CODE &&
		!st_r.c.setup1[dac_ctrl_pkg::BIT_LOAD_MODE_SELECT];
	endsequence
	sequence solo_wr_s;
		in_frame && sclk_fall && !chain && st_r.c.cnt == 6'h1f && !st_r.c.sh[30] &&
		st_r.c.sh[29:23] == dac_ctrl_pkg::A_CODE &&
		!st_r.c.setup1[dac_ctrl_pkg::BIT_LOAD_MODE_SELECT];
	endsequence
	sequence cal_go_s;
		st_r.syn.sup2 && commit && !word[31] && addr == dac_ctrl_pkg::A_TRIGGER &&
		word[dac_ctrl_pkg::BIT_THERMAL_CAL_START] && !st_r.c.cal_run;
	endsequence
	frame_start_a:
		assert property (st_r.syn.sup2 && sync_fall |=>
			st_r.c.fr == dac_ctrl_pkg::FR_SHIFT && st_r.c.cnt == 6'h00)
		else $error("frame did not open on select fall");
	bit_count_a:
		assert property (in_frame && sclk_fall && st_r.c.cnt != 6'h3f |=>
			st_r.c.cnt == $past(st_r.c.cnt) + 6'h01)
		else $error("bit count did not advance");
	fall_sample_a:
		assert property (in_frame && sclk_fall |=> st_r.c.sh[0] == $past(st_r.syn.s2.sdi))
		else $error("input bit not sampled on clock fall");
	rise_drive_a:
		assert property (in_frame && sclk_rise |=> SDO == $past(st_r.c.sh[31]))
		else $error("output bit not driven on clock rise");
	chain_update_a:
		assert property (chain_wr_s |=> DAC_CODE == $past(st_r.c.sh[23:4]))
		else $error("chained code not applied at select rise");
	solo_update_a:
		assert property (solo_wr_s |=> DAC_CODE == $past(st_r.c.sh[22:3]))
		else $error("code not applied at last clock fall");
	supply_hold_a:
		assert property (!st_r.syn.sup2 |=> DAC_CODE == 20'h00000 &&
			st_r.c.setup1 == dac_ctrl_pkg::SETUP1_RST && st_r.c.setup2 == dac_ctrl_pkg::SETUP2_RST)
		else $error("registers not at defaults during supply fault");
	mask_guard_a:
		assert property (st_r.syn.sup2 && commit && !word[31] && addr == dac_ctrl_pkg::A_SETUP1 &&
			(SETTLE_SPEED_SELECT || DEGLITCH_BYPASS) |=> $stable(DEGLITCH_STEP_MASK))
		else $error("mask changed while locked");
	cal_start_a:
		assert property (cal_go_s |=>
			CAL_BUSY == $past(st_r.c.setup1[dac_ctrl_pkg::BIT_THERMAL_CAL_ENABLE]) &&
			(!CAL_BUSY || !CAL_DONE_FLAG))
		else $error("calibration start mishandled");
	cal_end_a:
		assert property (st_r.syn.sup2 && CAL_BUSY && st_r.c.cal_cnt <= 16'h0001 |=>
			!CAL_BUSY && CAL_DONE_FLAG)
		else $error("calibration did not complete");
	alarm_pin_a:
		assert property (ALARM_N == !(CAL_DONE_FLAG && st_r.c.setup1[12]))
		else $error("alarm pin disagrees with completion flag");
endmodule : dac_serial_ctrl

/* rtl/dac_ctrl_pkg.sv */
// Constants and carrier types for the serial converter control block
package dac_ctrl_pkg;
	////////////////////////////////////////////////////////////////////////
	// Frame layout
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam logic [5:0] CNT_MAX = 6'h3f;
	localparam int RW_BIT = 31;
	localparam int ADDR_HI = 30;
	localparam int ADDR_LO = 24;
	localparam int DATA_HI = 23;
	localparam int DATA_LO = 4;
	////////////////////////////////////////////////////////////////////////
	// Serial register addresses
	localparam logic [6:0] A_IDLE = 7'h00;
	localparam logic [6:0] A_CODE = 7'h01;
	localparam logic [6:0] A_SETUP1 = 7'h02;
	localparam logic [6:0] A_CLEAR = 7'h03;
	localparam logic [6:0] A_TRIGGER = 7'h04;
	localparam logic [6:0] A_STATUS = 7'h05;
	localparam logic [6:0] A_SETUP2 = 7'h06;
	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_OUTPUT_POWER_DOWN = 4;
	localparam int BIT_CHAIN_DISABLE = 5;
	localparam int BIT_SETTLE_SPEED_SELECT = 10;
	localparam int BIT_ALARM_PIN_ENABLE = 12;
	localparam int BIT_LOAD_MODE_SELECT = 14;
	localparam int DEGLITCH_STEP_MASK_HI = 19;
	localparam int DEGLITCH_STEP_MASK_LO = 18;
	localparam int BIT_THERMAL_CAL_ENABLE = 23;
	localparam int BIT_THERMAL_CAL_START = 8;
	localparam int BIT_CAL_DONE_FLAG = 12;
	localparam int BIT_DEGLITCH_BYPASS = 7;
	localparam int UPDATE_RATE_HI = 5;
	localparam int UPDATE_RATE_LO = 4;
	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [23:0] CODE_RST = 24'h000000;
	localparam logic [23:0] SETUP1_RST = 24'h004c80;
	localparam logic [23:0] CLEAR_RST = 24'h000000;
	localparam logic [23:0] SETUP2_RST = 24'h000040;
	////////////////////////////////////////////////////////////////////////
	// Host bus registers
	localparam logic [3:0] AXI_CAL_OFF = 4'h0;
	localparam logic [3:0] AXI_STAT_OFF = 4'h4;
	localparam logic [15:0] CAL_CYCLES_RST = 16'h0100;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [0:0] {FR_IDLE = 1'h0, FR_SHIFT = 1'h1} frame_t;
	typedef struct packed {
		logic sclk;
		logic sync_n;
		logic sdi;
	} serial_in_t;
endpackage : dac_ctrl_pkg

/* rtl/dac_axi_regs.sv */
// AXI4-Lite slave holding the calibration length and showing block status
`timescale 1ns/1ps
module dac_axi_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write channels
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Block side
	input wire logic [31:0] stat_word,
	output logic [15:0] cal_cycles
);
	typedef struct packed {
		logic wr_take;
		logic bvalid;
		logic [1:0] bresp;
		logic rd_take;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] cal_cycles;
	} axi_st_t;
	localparam axi_st_t AXI_RST = '{cal_cycles: dac_ctrl_pkg::CAL_CYCLES_RST, default: '0};
	axi_st_t st_r;
	axi_st_t st_nxt;
	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.wr_take = awvalid && wvalid && !st_r.wr_take && !st_r.bvalid;
		st_nxt.rd_take = arvalid && !st_r.rd_take && !st_r.rvalid;
		// Address and data are taken together on the ready pulse
		if (st_r.wr_take)
		begin
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = dac_ctrl_pkg::RESP_SLVERR;
			if (awaddr == dac_ctrl_pkg::AXI_CAL_OFF)
			begin
				st_nxt.bresp = dac_ctrl_pkg::RESP_OKAY;
				if (wstrb[0])
					st_nxt.cal_cycles[7:0] = wdata[7:0];
				if (wstrb[1])
					st_nxt.cal_cycles[15:8] = wdata[15:8];
			end
			else if (awaddr == dac_ctrl_pkg::AXI_STAT_OFF)
				st_nxt.bresp = dac_ctrl_pkg::RESP_OKAY;
		end
		else if (st_r.bvalid && bready)
			st_nxt.bvalid = 1'b0;
		if (st_r.rd_take)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = dac_ctrl_pkg::RESP_OKAY;
			case (araddr)
				dac_ctrl_pkg::AXI_CAL_OFF: st_nxt.rdata = {16'h0000, st_r.cal_cycles};
				dac_ctrl_pkg::AXI_STAT_OFF: st_nxt.rdata = stat_word;
				default:
				begin
					st_nxt.rdata = 32'h00000000;
					st_nxt.rresp = dac_ctrl_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (st_r.rvalid && rready)
			st_nxt.rvalid = 1'b0;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			st_r <= AXI_RST;
		else
			st_r <= st_nxt;
	end
	assign awready = st_r.wr_take;
	assign wready = st_r.wr_take;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign arready = st_r.rd_take;
	assign rvalid = st_r.rvalid;
	assign rresp = st_r.rresp;
	assign rdata = st_r.rdata;
	assign cal_cycles = st_r.cal_cycles;
endmodule : dac_axi_regs

/* testbench/serial_host.sv */
// Behavioural serial host that frames words on the converter link
`timescale 1ns/1ps
module serial_host (
	// Link to the device
	output logic SCLK,
	output logic SYNC_N,
	output logic SDI,
	input wire logic SDO
);
	initial
	begin
		SCLK = 1'b0;
		SYNC_N = 1'b1;
		SDI = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// One frame of n clocks, MSB first; SDO gathered at each fall
	task frame(input logic [63:0] bits, input int n, output logic [63:0] got);
		int i;
		got = 64'h0;
		SYNC_N <= 1'b0;
		#150;
		for (i = n - 1; i >= 0; i--)
		begin
			SCLK <= 1'b1;
			SDI <= bits[i];
			#100;
			SCLK <= 1'b0;
			got = {got[62:0], SDO};
			#100;
		end
		#50;
		SYNC_N <= 1'b1;
		SDI <= ~SDI;
		#400;
	endtask : frame
endmodule : serial_host

/* testbench/tb_top.sv */
// Self-checking bench for the serial converter control block
`timescale 1ns/1ps
module tb_top;
	logic CLK = 1'b0, SYS_RST = 1'b1, SUPPLY_OK = 1'b1;
	logic SCLK, SYNC_N, SDI, SDO, ALARM_N;
	logic [19:0] DAC_CODE;
	logic OUTPUT_POWER_DOWN, DEGLITCH_BYPASS, SETTLE_SPEED_SELECT, CAL_BUSY, CAL_DONE_FLAG;
	logic [1:0] DEGLITCH_STEP_MASK, UPDATE_RATE, BRESP, RRESP;
	logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'h0;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [31:0] WDATA = 32'h0, RDATA, d;
	logic [63:0] g;
	int fail_count = 0, check_count = 0;
	initial
	begin
		forever #12.5 CLK = ~CLK;
	end
	serial_host host_u (.SCLK(SCLK), .SYNC_N(SYNC_N), .SDI(SDI), .SDO(SDO));
	dac_serial_ctrl dut_u (.CLK(CLK), .SYS_RST(SYS_RST), .SUPPLY_OK(SUPPLY_OK), .SCLK(SCLK),
		.SYNC_N(SYNC_N), .SDI(SDI), .SDO(SDO), .ALARM_N(ALARM_N), .DAC_CODE(DAC_CODE),
		.OUTPUT_POWER_DOWN(OUTPUT_POWER_DOWN), .DEGLITCH_BYPASS(DEGLITCH_BYPASS),
		.SETTLE_SPEED_SELECT(SETTLE_SPEED_SELECT), .DEGLITCH_STEP_MASK(DEGLITCH_STEP_MASK),
		.UPDATE_RATE(UPDATE_RATE), .CAL_BUSY(CAL_BUSY), .CAL_DONE_FLAG(CAL_DONE_FLAG),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY));
	////////////////////////////////////////////////////////////////////////
	// Reporting
	task test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task timed_out();
		fail_count++;
		test_done();
	endtask : timed_out
	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite master
	task axi_write(input logic [3:0] a, input logic [31:0] v);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b0;
		w = 1'b0;
		AWADDR <= a;
		AWVALID <= 1'b1;
		WDATA <= v;
		WSTRB <= 4'hf;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do
		begin
			@(posedge CLK);
			n++;
			if (AWREADY === 1'b1) begin aw = 1'b1; AWVALID <= 1'b0; end
			if (WREADY === 1'b1) begin w = 1'b1; WVALID <= 1'b0; end
		end
		while (!(aw && w) && n < 50);
		while (BVALID !== 1'b1 && n < 50)
		begin
			@(posedge CLK);
			n++;
		end
		if (n >= 50) timed_out();
		BREADY <= 1'b0;
		check(BRESP, dac_ctrl_pkg::RESP_OKAY);
		@(posedge CLK);
	endtask : axi_write
	task axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
		int n;
		n = 0;
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (ARREADY !== 1'b1 && n < 50);
		ARVALID <= 1'b0;
		while (RVALID !== 1'b1 && n < 50)
		begin
			@(posedge CLK);
			n++;
		end
		if (n >= 50) timed_out();
		v = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
		@(posedge CLK);
	endtask : axi_read
	////////////////////////////////////////////////////////////////////////
	// Serial accesses
	task wr(input logic [6:0] a, input logic [23:0] v);
		host_u.frame({32'h0, 1'b0, a, v}, 32, g);
	endtask : wr
	task rd(input logic [6:0] a);
		host_u.frame({32'h0, 1'b1, a, 24'h0}, 32, g);
		host_u.frame(64'h0, 32, g);
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	initial
	begin
		logic [1:0] r;
		int n;
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'b0;
		repeat (8) @(posedge CLK);
		check({OUTPUT_POWER_DOWN, DEGLITCH_BYPASS, SETTLE_SPEED_SELECT}, 32'h1);
		check({DAC_CODE, UPDATE_RATE, DEGLITCH_STEP_MASK, ALARM_N}, 32'h1);
		rd(dac_ctrl_pkg::A_SETUP1);
		check(g[31:0], {8'h82, dac_ctrl_pkg::SETUP1_RST});
		wr(dac_ctrl_pkg::A_CODE, 24'h777770);
		check(DAC_CODE, 32'h0);
		rd(dac_ctrl_pkg::A_CODE);
		check(g[31:0], 32'h81777770);
		wr(dac_ctrl_pkg::A_SETUP1, 24'h000c80);
		host_u.frame({32'h0, 8'h01, 20'habcde, 4'hf}, 32, g);
		check(DAC_CODE, 32'habcde);
		rd(dac_ctrl_pkg::A_CODE);
		check(g[31:0], 32'h81abcde0);
		host_u.frame({32'h0, 8'h01, 20'h12345, 4'h0}, 16, g);
		check(DAC_CODE, 32'habcde);
		host_u.frame({32'h01234567, 8'h01, 20'h55aa5, 4'h0}, 64, g);
		check(DAC_CODE, 32'h55aa5);
		check(g[31:0], 32'h01234567);
		wr(dac_ctrl_pkg::A_SETUP1, 24'h000ca0);
		host_u.frame({8'h01, 20'h0f0f0, 4'h0, 8'h01, 20'h11111, 4'h0}, 64, g);
		check(DAC_CODE, 32'h0f0f0);
		wr(dac_ctrl_pkg::A_SETUP1, 24'h0c0c90);
		check({OUTPUT_POWER_DOWN, DEGLITCH_STEP_MASK}, 32'h4);
		wr(dac_ctrl_pkg::A_SETUP1, 24'h000880);
		wr(dac_ctrl_pkg::A_SETUP1, 24'h0c0880);
		check({SETTLE_SPEED_SELECT, DEGLITCH_STEP_MASK}, 32'h3);
		wr(dac_ctrl_pkg::A_SETUP2, 24'h0000d0);
		check({DEGLITCH_BYPASS, UPDATE_RATE}, 32'h5);
		wr(dac_ctrl_pkg::A_SETUP1, 24'h000880);
		check(DEGLITCH_STEP_MASK, 32'h3);
		axi_write(dac_ctrl_pkg::AXI_CAL_OFF, 32'h10);
		wr(dac_ctrl_pkg::A_TRIGGER, 24'h000100);
		check(CAL_BUSY, 32'h0);
		wr(dac_ctrl_pkg::A_SETUP1, 24'h8c1880);
		host_u.frame({32'h0, 8'h04, 24'h000100}, 32, g);
		check({CAL_BUSY, CAL_DONE_FLAG}, 32'h2);
		n = 0;
		// No frame is sent until the calibration has finished
		while (CAL_DONE_FLAG !== 1'b1 && n < 400)
		begin
			@(posedge CLK);
			n++;
		end
		if (n >= 400) timed_out();
		@(posedge CLK);
		check({CAL_BUSY, ALARM_N}, 32'h0);
		rd(dac_ctrl_pkg::A_STATUS);
		check({31'h0, g[12]}, 32'h1);
		axi_read(dac_ctrl_pkg::AXI_STAT_OFF, d, r);
		check(d[1:0], 32'h2);
		axi_read(4'h8, d, r);
		check({d, r}, {32'h0, dac_ctrl_pkg::RESP_SLVERR});
		SUPPLY_OK <= 1'b0;
		repeat (6) @(posedge CLK);
		check({DAC_CODE, SETTLE_SPEED_SELECT, DEGLITCH_BYPASS}, 32'h2);
		SUPPLY_OK <= 1'b1;
		repeat (8) @(posedge CLK);
		axi_read(dac_ctrl_pkg::AXI_CAL_OFF, d, r);
		check(d[15:0], 32'h10);
		test_done();
	end
endmodule : tb_top
